/* File: emap_port.sv */
// Purpose: External parallel memory access port driven from CPU I/O registers.
// Assumes: The CPU issues one request at a time and waits for cpuAck.
// Notes: A byte moves as two nibbles; the high nibble completes a write.
`timescale 1ns/100ps
// Overview of operation
// R1 - Chip-select float bit drives four select pins when 1, floats them when 0.
// R2 - Writing 1 to the step command bit increments the 14-bit address.
// R3 - Auto-step enable picks automatic increment when 1; cleared at reset.
// R4 - Address bits come from the four output nibble registers in order.
// R5 - With a read-write device the address bit 13 pin becomes write strobe.
// R6 - Data bits 3..0 use the low nibble register, 7..4 the high one.
// R7 - Software moves each byte low nibble first, then high nibble.
// R8 - Data register writes give a write strobe, reads a read strobe.
// R9 - Build option chooses which address pins take part; others stay outputs.
// R10 - Even virtual addresses reach the low nibble, odd the high nibble.
// R11 - Each select register bit maps to one pin; 0 selects, 1 deselects.
// R12 - A selected pin goes low only during an access, then returns high.
// R13 - Software writes the select register whole, never read-modify-write.
// R14 - Pull-ups are on while the select pins float.
// R15 - Auto mode advances the address on data accesses without software.
// R16 - Address and data registers hold no guaranteed value after reset.
// R17 - Four float bits each drive or float one address pin group.
// R18 - Auto mode steps once per byte, after the high nibble access.
module emap_port #(
  parameter logic [13:0] ADDR_PIN_EN = emap_pkg::ADDR_PIN_EN_DFLT,
  parameter bit RW_DEVICE = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // CPU register port
  input wire emap_pkg::emap_cpu_req_t cpuReq,
  output logic [3:0] cpuRdData,
  output logic cpuAck,
  // External bus
  input wire logic [7:0] extDataIn,
  output emap_pkg::emap_pins_t extPins
);

  logic [13:0] addr_r;
  logic [13:0] addr_nxt;
  logic [1:0] portHi_r;
  logic [3:0] loNib_r;
  logic [3:0] hiNib_r;
  logic [3:0] csSel_r;
  logic [3:0] addrFloat_r;
  logic csFloat_r;
  logic autoStep_r;
  logic busy_r;
  logic accWrite_r;
  logic [7:0] dataS1_r;
  logic [7:0] dataS2_r;
  logic [3:0] rdData_r;
  logic [3:0] rdData_nxt;
  logic ack_r;
  emap_pkg::emap_pins_t pins_r;
  emap_pkg::emap_pins_t pins_nxt;
  logic seqActive;
  logic seqDone;

  // Decode; requests arriving while an external strobe runs are ignored.
  wire logic [11:0] a = cpuReq.addr;
  wire logic [3:0] d = cpuReq.wrData;
  wire logic wrReq = cpuReq.wrEn && !busy_r;
  wire logic rdReq = cpuReq.rdEn && !cpuReq.wrEn && !busy_r;
  wire logic hitA0 = (a == emap_pkg::OFF_ADDR0);
  wire logic hitA1 = (a == emap_pkg::OFF_ADDR1);
  wire logic hitA2 = (a == emap_pkg::OFF_ADDR2);
  wire logic hitA3 = (a == emap_pkg::OFF_ADDR3);
  wire logic hitLo = (a == emap_pkg::OFF_DATA_LO) || (emap_pkg::isVirt(a) && !a[0]); // see R10
  wire logic hitHi = (a == emap_pkg::OFF_DATA_HI) || (emap_pkg::isVirt(a) && a[0]); // see R10
  wire logic hitCs = (a == emap_pkg::OFF_CHIP_SEL);
  wire logic hitFlt = (a == emap_pkg::OFF_ADDR_FLOAT);
  wire logic hitCtl = (a == emap_pkg::OFF_EXT_BUS_CTL);

  // The high nibble write closes the byte and starts the write strobe; the low
  // nibble read starts the read strobe and fetches the whole byte.
  wire logic startWr = wrReq && hitHi; // see R8
  wire logic startRd = rdReq && hitLo; // see R8
  wire logic stepCmd = wrReq && hitCtl && d[emap_pkg::CTL_STEP_BIT]; // see R2
  wire logic autoInc = autoStep_r && ((seqDone && accWrite_r) || (rdReq && hitHi)); // see R15 R18
  wire logic rdDone = seqDone && !accWrite_r;

  emap_strobe_seq u_seq (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(startWr || startRd),
    .active(seqActive),
    .done(seqDone)
  );

  // Address register writes, then stepping.
  wire logic [13:0] addrWrVal =
    hitA0 ? {addr_r[13:4], d} :
    hitA1 ? {addr_r[13:8], d, addr_r[3:0]} :
    hitA2 ? {addr_r[13:12], d, addr_r[7:0]} :
    {d[1:0], addr_r[11:0]}; // see R4
  wire logic addrWr = wrReq && (hitA0 || hitA1 || hitA2 || hitA3);
  assign addr_nxt = addrWr ? addrWrVal :
    (stepCmd || autoInc) ? emap_pkg::stepAddr(addr_r, ADDR_PIN_EN) : addr_r; // see R2 R9

  // Register read mux; the select register is write-only and reads zero.
  wire logic [3:0] regVal =
    hitA0 ? addr_r[3:0] :
    hitA1 ? addr_r[7:4] :
    hitA2 ? addr_r[11:8] :
    hitA3 ? {portHi_r, addr_r[13:12]} :
    hitHi ? hiNib_r :
    hitFlt ? addrFloat_r :
    hitCtl ? {1'b0, csFloat_r, 1'b0, autoStep_r} : 4'h0;
  assign rdData_nxt = rdDone ? dataS2_r[3:0] : rdReq ? regVal : rdData_r;

  // Pin values; strobes and selects are only active inside a strobe window.
  wire logic strobeWr = seqActive && accWrite_r;
  wire logic strobeRd = seqActive && !accWrite_r;
  wire logic wrPin = !strobeWr;
  assign pins_nxt.addrOut = {RW_DEVICE ? wrPin : addr_r[13], addr_r[12:0]}; // see R4 R5
  assign pins_nxt.addrOe = addrFloat_r; // see R17
  assign pins_nxt.r33Out = portHi_r[1];
  assign pins_nxt.dataOut = {hiNib_r, loNib_r}; // see R6
  assign pins_nxt.dataOe = strobeWr;
  assign pins_nxt.rdN = !strobeRd; // see R8
  assign pins_nxt.wrN = wrPin; // see R8
  assign pins_nxt.csN = (strobeWr || strobeRd) ? csSel_r : 4'hF; // see R11 R12
  assign pins_nxt.csOe = csFloat_r; // see R1
  assign pins_nxt.csPullup = !csFloat_r; // see R14

  // Pin inputs pass two flip-flops before the capture.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataS1_r <= 8'h00;
      dataS2_r <= 8'h00;
    end
    else
    begin
      dataS1_r <= extDataIn;
      dataS2_r <= dataS1_r;
    end
  end

  // Address and data registers have no defined reset value to software; they
  // are cleared here only so the pins never show unknowns.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_r <= emap_pkg::ADDR_RST; // see R16
      portHi_r <= 2'h0;
      loNib_r <= emap_pkg::NIB_RST;
      hiNib_r <= emap_pkg::NIB_RST;
    end
    else
    begin
      addr_r <= addr_nxt;
      if (wrReq && hitA3)
        portHi_r <= d[3:2];
      if (wrReq && hitLo)
        loNib_r <= d; // see R6 R10
      else if (rdDone)
        loNib_r <= dataS2_r[3:0];
      if (wrReq && hitHi)
        hiNib_r <= d; // see R6 R10
      else if (rdDone)
        hiNib_r <= dataS2_r[7:4];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csSel_r <= emap_pkg::CS_SEL_RST;
      addrFloat_r <= emap_pkg::ADDR_FLOAT_RST; // see R17
      csFloat_r <= 1'b0; // see R1
      autoStep_r <= 1'b0; // see R3
    end
    else
    begin
      if (wrReq && hitCs)
        csSel_r <= d; // see R11 R13
      if (wrReq && hitFlt)
        addrFloat_r <= d;
      if (wrReq && hitCtl)
      begin
        csFloat_r <= d[emap_pkg::CTL_CSFLOAT_BIT];
        autoStep_r <= d[emap_pkg::CTL_AUTO_BIT]; // see R3
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      accWrite_r <= 1'b0;
      rdData_r <= 4'h0;
      ack_r <= 1'b0;
      pins_r <= emap_pkg::PINS_RST;
    end
    else
    begin
      busy_r <= (startWr || startRd) || (busy_r && !seqDone);
      if (startWr || startRd)
        accWrite_r <= startWr;
      rdData_r <= rdData_nxt;
      ack_r <= seqDone || (wrReq && !hitHi) || (rdReq && !hitLo);
      pins_r <= pins_nxt;
    end
  end

  assign cpuRdData = rdData_r;
  assign cpuAck = ack_r;
  assign extPins = pins_r;

  // Checks.
  sequence wrStrobeSeq;
    ##2 (!pins_r.wrN)[*4] ##1 pins_r.wrN;
  endsequence
  sequence rdStrobeSeq;
    ##2 (!pins_r.rdN)[*4] ##1 pins_r.rdN ##0 ack_r;
  endsequence

  chk_cs_float_oe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R1
    ##1 pins_r.csOe == $past(csFloat_r)) else $error("select enable does not follow float bit");
  chk_cs_pull_up: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R14
    pins_r.csPullup == !pins_r.csOe) else $error("pull-up wrong while selects float");
  chk_step_cmd_inc: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R2
    stepCmd |=> addr_r == emap_pkg::stepAddr($past(addr_r), ADDR_PIN_EN))
    else $error("step command did not advance the address");
  chk_auto_off_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R3
    (!autoStep_r && !stepCmd && !addrWr) |=> $stable(addr_r))
    else $error("address moved in normal mode");
  chk_addr_pin_map: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R4
    ##1 pins_r.addrOut[12:0] == $past(addr_r[12:0])) else $error("address pins mismatch");
  chk_wr_pin_a13: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R5
    RW_DEVICE |-> pins_r.addrOut[13] == pins_r.wrN) else $error("bit 13 pin is not write strobe");
  chk_write_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R8
    startWr |-> wrStrobeSeq) else $error("write strobe shape wrong");
  chk_read_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R8
    startRd |-> rdStrobeSeq) else $error("read strobe shape wrong");
  chk_write_data: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R6
    !pins_r.wrN |-> pins_r.dataOe && pins_r.dataOut == {hiNib_r, loNib_r})
    else $error("write data not on the bus");
  chk_virt_lo_map: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R10
    (wrReq && emap_pkg::isVirt(a) && !a[0]) |=> loNib_r == $past(cpuReq.wrData))
    else $error("even virtual write missed low nibble");
  chk_cs_in_access: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R12
    (pins_r.csN != 4'hF) |-> (!pins_r.wrN || !pins_r.rdN) && pins_r.csN == csSel_r)
    else $error("select low outside an access");
  chk_auto_step_byte: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R18
    (autoStep_r && seqDone && accWrite_r) |=> addr_r == emap_pkg::stepAddr($past(addr_r),
    ADDR_PIN_EN)) else $error("auto step missing after byte write");
  chk_addr_float: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R17
    (wrReq && hitFlt) |=> ##1 pins_r.addrOe == $past(cpuReq.wrData, 2))
    else $error("address float bits not applied");

endmodule : emap_port

/* File: emap_pkg.sv */
// Purpose: Shared constants, types and helpers for the external memory access port.
// Assumes: CPU I/O space is 12 bits wide with 4-bit data; clk_sys runs at 50 MHz.
// Notes: Register offsets are the CPU's I/O data memory addresses.
package emap_pkg;

  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets.
  localparam logic [11:0] OFF_ADDR0 = 12'hF50;
  localparam logic [11:0] OFF_ADDR1 = 12'hF51;
  localparam logic [11:0] OFF_ADDR2 = 12'hF52;
  localparam logic [11:0] OFF_ADDR3 = 12'hF53;
  localparam logic [11:0] OFF_DATA_LO = 12'hF60;
  localparam logic [11:0] OFF_DATA_HI = 12'hF61;
  localparam logic [11:0] OFF_CHIP_SEL = 12'hF62;
  localparam logic [11:0] OFF_ADDR_FLOAT = 12'hF7B;
  localparam logic [11:0] OFF_EXT_BUS_CTL = 12'hF7C;
  localparam logic [11:0] VIRT_BASE = 12'hFC0;
  localparam logic [11:0] VIRT_MASK = 12'hFC0;

  // Fields of external_bus_control.
  localparam int CTL_AUTO_BIT = 0;
  localparam int CTL_STEP_BIT = 1;
  localparam int CTL_CSFLOAT_BIT = 2;

  // Reset values and build options.
  localparam logic [3:0] ADDR_FLOAT_RST = 4'h0;
  localparam logic [3:0] CS_SEL_RST = 4'hF;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [13:0] ADDR_RST = 14'h0000;
  localparam logic [13:0] ADDR_PIN_EN_DFLT = 14'h3FFF;
  localparam logic [13:0] ADDR_ONE = 14'h0001;

  typedef struct packed {
    logic [11:0] addr;
    logic wrEn;
    logic rdEn;
    logic [3:0] wrData;
  } emap_cpu_req_t;

  typedef struct packed {
    logic [13:0] addrOut;
    logic [3:0] addrOe;
    logic r33Out;
    logic [7:0] dataOut;
    logic dataOe;
    logic rdN;
    logic wrN;
    logic [3:0] csN;
    logic csOe;
    logic csPullup;
  } emap_pins_t;

  localparam emap_pins_t PINS_RST = '{addrOut: 14'h0000, addrOe: 4'h0, r33Out: 1'b0,
    dataOut: 8'h00, dataOe: 1'b0, rdN: 1'b1, wrN: 1'b1, csN: 4'hF, csOe: 1'b0,
    csPullup: 1'b1};

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_STROBE = 3'b010,
    SEQ_DONE = 3'b100
  } emap_seq_state_t;

  // Bits that are plain output ports keep their value when the address steps.
  function automatic logic [13:0] stepAddr(input logic [13:0] a, input logic [13:0] en);
    logic [13:0] inc;
    inc = a + ADDR_ONE;
    return (a & ~en) | (inc & en);
  endfunction : stepAddr

  function automatic logic isVirt(input logic [11:0] a);
    return (a & VIRT_MASK) == VIRT_BASE;
  endfunction : isVirt

endpackage : emap_pkg

/* File: emap_strobe_seq.sv */
// Purpose: Times one external strobe of fixed length.
// Assumes: start is a one-cycle pulse given only while idle.
// Notes: active stands for STROBE_CYC cycles, then done pulses once.
`timescale 1ns/100ps
module emap_strobe_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Control
  input wire logic start,
  output logic active,
  output logic done
);

  emap_pkg::emap_seq_state_t state_r;
  emap_pkg::emap_seq_state_t state_nxt;
  logic [2:0] count_r;
  logic [2:0] count_nxt;
  wire logic lastCyc = (count_r == 3'h0);

  always_comb
  begin
    state_nxt = state_r;
    count_nxt = count_r;
    unique case (state_r)
      emap_pkg::SEQ_IDLE:
      begin
        if (start)
        begin
          state_nxt = emap_pkg::SEQ_STROBE;
          count_nxt = 3'(emap_pkg::STROBE_CYC - 1);
        end
      end
      emap_pkg::SEQ_STROBE:
      begin
        count_nxt = count_r - 3'h1;
        if (lastCyc)
        begin
          state_nxt = emap_pkg::SEQ_DONE;
          count_nxt = 3'h0;
        end
      end
      emap_pkg::SEQ_DONE:
      begin
        state_nxt = emap_pkg::SEQ_IDLE;
      end
      default:
      begin
        state_nxt = emap_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= emap_pkg::SEQ_IDLE;
      count_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign active = (state_r == emap_pkg::SEQ_STROBE);
  assign done = (state_r == emap_pkg::SEQ_DONE);

endmodule : emap_strobe_seq

/* File: emap_ext_mem.sv */
// Purpose: Behavioural external memory on the far side of the access port.
// Assumes: Strobes last several cycles; address and data are steady while a strobe is low.
// Notes: Outside a selected read the data lines show a pattern that changes every cycle.
`timescale 1ns/100ps
module emap_ext_mem (
  // Clock
  input wire logic clk_sys,
  // Bus pins
  input wire emap_pkg::emap_pins_t pins,
  output logic [7:0] extDataIn,
  // Observation
  output logic [13:0] lastAddr,
  output logic [3:0] lastCs
);
  logic [7:0] mem [0:16383];
  logic prevRdN = 1'b1;
  logic prevWrN = 1'b1;
  logic [7:0] idleVal = 8'hA5;
  wire selected = pins.csN != 4'hF;
  wire rdStart = prevRdN && !pins.rdN;
  wire wrStart = prevWrN && !pins.wrN;
  // A released bus must not look like held data, so the idle value keeps moving.
  assign extDataIn = (!pins.rdN && selected) ? mem[pins.addrOut] : idleVal;
  always @(posedge clk_sys)
  begin
    prevRdN <= pins.rdN;
    prevWrN <= pins.wrN;
    idleVal <= ~idleVal;
    if (rdStart || wrStart)
    begin
      lastAddr <= pins.addrOut;
      lastCs <= pins.csN;
    end
    if (wrStart && selected)
      mem[pins.addrOut] <= pins.dataOut;
  end
endmodule : emap_ext_mem

/* File: emap_port_tb_top.sv */
// Purpose: Self-checking bench for the external memory access port.
// Assumes: Default build options; one CPU request in flight at a time.
// Notes: Acks are matched by a monitor against notes queued by the driver.
`timescale 1ns/100ps
module emap_port_tb_top;
  logic clk_sys;
  logic rst_b;
  emap_pkg::emap_cpu_req_t cpuReq;
  logic [3:0] cpuRdData;
  logic cpuAck;
  logic [7:0] extDataIn;
  emap_pkg::emap_pins_t extPins;
  logic [13:0] memAddr;
  logic [3:0] memCs;
  logic [4:0] expQ[$];
  logic [4:0] note;
  logic [13:0] baseAddr;
  logic [7:0] bytes [0:3];
  logic [3:0] csList [0:3] = '{4'hE, 4'hD, 4'hB, 4'h7};
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'h0fb4a155;

  emap_port DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cpuReq(cpuReq), .cpuRdData(cpuRdData),
    .cpuAck(cpuAck), .extDataIn(extDataIn), .extPins(extPins));
  emap_ext_mem partner (.clk_sys(clk_sys), .pins(extPins), .extDataIn(extDataIn),
    .lastAddr(memAddr), .lastCs(memCs));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic checkVal(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : checkVal

  task automatic checkAddr(input string what, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : checkAddr

  // One request, then wait for its ack; read notes carry the expected nibble.
  task automatic access(input logic [11:0] a, input bit rd, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpuReq.addr <= a;
    cpuReq.wrEn <= !rd;
    cpuReq.rdEn <= rd;
    cpuReq.wrData <= d;
    expQ.push_back({rd, d});
    @(posedge clk_sys);
    cpuReq.wrEn <= 1'b0;
    cpuReq.rdEn <= 1'b0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (cpuAck !== 1'b1 && n < 20);
    if (n >= 20)
      checkVal("ack", 4'h1, 4'h0);
    // Pins are registered one cycle after the register they show, so let them settle.
    @(negedge clk_sys);
  endtask : access

  task automatic setAddr(input logic [13:0] a);
    access(emap_pkg::OFF_ADDR0, 0, a[3:0]);
    access(emap_pkg::OFF_ADDR1, 0, a[7:4]);
    access(emap_pkg::OFF_ADDR2, 0, a[11:8]);
    access(emap_pkg::OFF_ADDR3, 0, {2'b00, a[13:12]});
  endtask : setAddr

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  always @(negedge clk_sys)
  begin
    if (rst_b && extPins.rdN && extPins.wrN)
      checkVal("csN idle", 4'hF, extPins.csN);
    if (cpuAck === 1'b1)
    begin
      if (expQ.size() == 0)
        checkVal("unexpected ack", 4'h0, 4'h1);
      else
      begin
        note = expQ.pop_front();
        if (note[4])
          checkVal("cpuRdData", note[3:0], cpuRdData);
      end
    end
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    checkVal("watchdog", 4'h0, 4'h1);
    end_sim();
  end

  initial
  begin
    rst_b = 1'b0;
    cpuReq = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    checkVal("csOe", 4'h0, {3'h0, extPins.csOe});
    checkVal("csPullup", 4'h1, {3'h0, extPins.csPullup});
    checkVal("addrOe", 4'h0, extPins.addrOe);
    access(emap_pkg::OFF_EXT_BUS_CTL, 1, 4'h0);
    $display("test reset done");
    baseAddr = 14'($random(seed));
    setAddr(baseAddr);
    access(emap_pkg::OFF_ADDR_FLOAT, 0, 4'hF);
    checkVal("addrOe", 4'hF, extPins.addrOe);
    checkAddr("addrOut", baseAddr, extPins.addrOut);
    access(emap_pkg::OFF_CHIP_SEL, 0, 4'hE);
    access(emap_pkg::OFF_EXT_BUS_CTL, 0, 4'h5);
    checkVal("csOe", 4'h1, {3'h0, extPins.csOe});
    checkVal("csPullup", 4'h0, {3'h0, extPins.csPullup});
    access(emap_pkg::OFF_EXT_BUS_CTL, 1, 4'h5);
    access(emap_pkg::OFF_CHIP_SEL, 1, 4'h0);
    access(12'hF70, 1, 4'h0);
    access(emap_pkg::OFF_ADDR0, 1, baseAddr[3:0]);
    access(emap_pkg::OFF_ADDR3, 0, {2'b10, baseAddr[13:12]});
    access(emap_pkg::OFF_ADDR3, 1, {2'b10, baseAddr[13:12]});
    checkVal("r33Out", 4'h1, {3'h0, extPins.r33Out});
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      bytes[i] = 8'($random(seed));
      access(emap_pkg::VIRT_BASE + 12'(8 * i), 0, bytes[i][3:0]);
      access(emap_pkg::VIRT_BASE + 12'(8 * i + 1), 0, bytes[i][7:4]);
      checkAddr("write address", baseAddr + 14'(i), memAddr);
      checkVal("write select", 4'hE, memCs);
    end
    $display("test auto write done");
    access(emap_pkg::OFF_EXT_BUS_CTL, 0, 4'h4);
    setAddr(baseAddr);
    access(emap_pkg::OFF_DATA_LO, 1, bytes[0][3:0]);
    access(emap_pkg::OFF_DATA_HI, 1, bytes[0][7:4]);
    checkAddr("read address", baseAddr, memAddr);
    access(emap_pkg::OFF_EXT_BUS_CTL, 0, 4'h6);
    access(emap_pkg::VIRT_BASE + 12'h002, 1, bytes[1][3:0]);
    access(emap_pkg::VIRT_BASE + 12'h003, 1, bytes[1][7:4]);
    checkAddr("step address", baseAddr + 14'h0001, memAddr);
    // The step moves past byte 1 so that the auto reads start at byte 2.
    access(emap_pkg::OFF_EXT_BUS_CTL, 0, 4'h7);
    for (int i = 2; i < 4; i++)
    begin
      access(emap_pkg::OFF_DATA_LO, 1, bytes[i][3:0]);
      access(emap_pkg::OFF_DATA_HI, 1, bytes[i][7:4]);
      checkAddr("auto read address", baseAddr + 14'(i), memAddr);
    end
    $display("test reads done");
    for (int i = 0; i < 4; i++)
    begin
      setAddr(baseAddr);
      access(emap_pkg::OFF_CHIP_SEL, 0, csList[i]);
      access(emap_pkg::OFF_DATA_LO, 1, bytes[0][3:0]);
      checkVal("read select", csList[i], memCs);
    end
    access(emap_pkg::OFF_EXT_BUS_CTL, 0, 4'h0);
    access(emap_pkg::OFF_ADDR_FLOAT, 0, 4'h0);
    checkVal("csOe", 4'h0, {3'h0, extPins.csOe});
    checkVal("csPullup", 4'h1, {3'h0, extPins.csPullup});
    checkVal("addrOe", 4'h0, extPins.addrOe);
    $display("test selects done");
    end_sim();
  end
endmodule : emap_port_tb_top
